/* common/wpd_pkg.sv */
// package for the watchdog pin disable lock register block
package wpd_pkg;
  // register byte addresses on the internal configuration bus
  localparam logic [7:0] KEY_REGISTER_ADDR = 8'h34;
  localparam logic [7:0] CONTROL_ADDR = 8'h35;
  // unlock key bytes, in the order they must arrive
  localparam logic [7:0] KEY_BYTE_0 = 8'h87;
  localparam logic [7:0] KEY_BYTE_1 = 8'h65;
  localparam logic [7:0] KEY_BYTE_2 = 8'h1B;
  // field positions in the control register
  localparam int PERMIT_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int RSVD_LSB = 2;
  // values after reset
  localparam logic PERMIT_RESET = 1'b0;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic [5:0] RSVD_RESET = 6'h00;
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;

  // key sequence tracker states
  typedef enum logic [2:0] {
    WPD_WAIT_B0 = 3'b001,
    WPD_WAIT_B1 = 3'b010,
    WPD_WAIT_B2 = 3'b100
  } wpd_seq_t;

  // register access request as seen from the serial slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wpd_req_t;

  // whole state of the block
  typedef struct packed {
    wpd_seq_t seq;
    logic lock;
    logic permit;
    logic [5:0] rsvd;
    logic [7:0] rdata;
  } wpd_state_t;
endpackage

/* src/wpd_lock.sv */
// watchdog pin disable permit with key lock, register side
// Summary of operation
// (RULE1) key lock status is read-only and comes out of reset locked; locked freezes permit
// (RULE2) lock reads 0 while permit is writable, 1 while permit is frozen
// (RULE3) writes 0x87, 0x65, 0x1B to key register unlock, only while config lock clear
// (RULE4) any other key register write, or config lock written to one, relocks
// (RULE5) permit resets to 0; 0 blocks the disable pin, 1 lets it disable
// (RULE6) permit takes a write of one only when both locks read zero
// (RULE7) key register always reads back 0x00
// (RULE8) a mismatching key byte restarts tracking from the first byte
`timescale 1ns/100ps
`default_nettype none
module wpd_lock (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register access from the serial slave
  input wire wpd_pkg::wpd_req_t req,
  output logic [7:0] rdata,
  // watchdog side
  input wire logic watchdog_config_lock,
  input wire logic watchdog_config_lock_set,
  input wire logic watchdog_disable_pin,
  output logic key_lock_status,
  output logic pin_disable_permit,
  output logic watchdog_disable_req
);

  wpd_pkg::wpd_state_t s_q;
  wpd_pkg::wpd_state_t s_d;

  // expected key byte for a tracker state
  function automatic logic [7:0] expect_byte(input wpd_pkg::wpd_seq_t st);
    case (st)
      wpd_pkg::WPD_WAIT_B0: expect_byte = wpd_pkg::KEY_BYTE_0;
      wpd_pkg::WPD_WAIT_B1: expect_byte = wpd_pkg::KEY_BYTE_1;
      wpd_pkg::WPD_WAIT_B2: expect_byte = wpd_pkg::KEY_BYTE_2;
      default: expect_byte = wpd_pkg::KEY_BYTE_0;
    endcase
  endfunction

  // one address decoder shared by the write and read paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  logic key_wr;
  logic ctl_wr;
  logic key_hit;
  assign key_wr = req.wr && addr_is(req.addr, wpd_pkg::KEY_REGISTER_ADDR);
  assign ctl_wr = req.wr && addr_is(req.addr, wpd_pkg::CONTROL_ADDR);
  assign key_hit = key_wr && (req.wdata == expect_byte(s_q.seq));

  // next state: key tracker, lock, permit and read data
  always_comb begin
    s_d = s_q;
    if (key_wr) begin
      if (!key_hit) begin
        // a wrong byte may itself be the first key byte
        if (req.wdata == wpd_pkg::KEY_BYTE_0) begin // RULE8
          s_d.seq = wpd_pkg::WPD_WAIT_B1;
        end else begin
          s_d.seq = wpd_pkg::WPD_WAIT_B0; // RULE8
        end
        s_d.lock = 1'b1; // RULE4
      end else begin
        case (s_q.seq)
          wpd_pkg::WPD_WAIT_B0: begin
            s_d.seq = wpd_pkg::WPD_WAIT_B1;
            s_d.lock = 1'b1; // RULE4
          end
          wpd_pkg::WPD_WAIT_B1: begin
            s_d.seq = wpd_pkg::WPD_WAIT_B2;
            s_d.lock = 1'b1; // RULE4
          end
          wpd_pkg::WPD_WAIT_B2: begin
            s_d.seq = wpd_pkg::WPD_WAIT_B0;
            // unlock refused while the watchdog config is locked
            s_d.lock = watchdog_config_lock; // RULE3
          end
          default: s_d.seq = wpd_pkg::WPD_WAIT_B0;
        endcase
      end
    end
    // config lock has priority over a completing key
    if (watchdog_config_lock_set) begin
      s_d.lock = 1'b1; // RULE4
    end
    if (ctl_wr) begin
      s_d.rsvd = req.wdata[7:wpd_pkg::RSVD_LSB];
      // clearing to 0 needs only the key lock open; setting needs both locks open
      if (!req.wdata[wpd_pkg::PERMIT_BIT] || (!s_q.lock && !watchdog_config_lock)) begin // RULE6
        s_d.permit = req.wdata[wpd_pkg::PERMIT_BIT] && !s_q.lock ? 1'b1 : (s_q.lock ? s_q.permit : 1'b0); // RULE1
      end
    end
    // read data registered one cycle after the strobe
    if (req.rd) begin
      if (addr_is(req.addr, wpd_pkg::CONTROL_ADDR)) begin
        s_d.rdata = {s_q.rsvd, s_q.lock, s_q.permit}; // RULE2
      end else begin
        s_d.rdata = wpd_pkg::KEY_READ_VALUE; // RULE7
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.seq <= wpd_pkg::WPD_WAIT_B0;
      s_q.lock <= wpd_pkg::LOCK_RESET; // RULE1
      s_q.permit <= wpd_pkg::PERMIT_RESET; // RULE5
      s_q.rsvd <= wpd_pkg::RSVD_RESET;
      s_q.rdata <= wpd_pkg::KEY_READ_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign key_lock_status = s_q.lock;
  assign pin_disable_permit = s_q.permit;
  // pin only acts when permitted
  assign watchdog_disable_req = s_q.permit && watchdog_disable_pin; // RULE5

  // permit never changes while locked
  property p_frozen;
    @(posedge ref_clk) disable iff (!resetn)
      $past(s_q.lock) |-> s_q.permit == $past(s_q.permit);
  endproperty
  a_frozen: assert property (p_frozen) else $error("permit changed while locked"); // RULE1

  property p_unlock;
    @(posedge ref_clk) disable iff (!resetn)
      (key_wr && req.wdata == wpd_pkg::KEY_BYTE_0 && s_q.seq == wpd_pkg::WPD_WAIT_B0)
      ##1 (key_wr && req.wdata == wpd_pkg::KEY_BYTE_1 && !watchdog_config_lock_set)
      ##1 (key_wr && req.wdata == wpd_pkg::KEY_BYTE_2 && !watchdog_config_lock
           && !watchdog_config_lock_set)
      |=> !s_q.lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key sequence did not unlock"); // RULE3

  property p_relock;
    @(posedge ref_clk) disable iff (!resetn)
      (key_wr && !key_hit) || watchdog_config_lock_set |=> s_q.lock;
  endproperty
  a_relock: assert property (p_relock) else $error("lock not closed"); // RULE4

  property p_set_permit;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(s_q.permit) |-> !$past(s_q.lock) && !$past(watchdog_config_lock) && $past(ctl_wr);
  endproperty
  a_set_permit: assert property (p_set_permit) else $error("permit set without open locks"); // RULE6

  property p_key_read;
    @(posedge ref_clk) disable iff (!resetn)
      req.rd && req.addr == wpd_pkg::KEY_REGISTER_ADDR |=> rdata == 8'h00;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key register read not zero"); // RULE7

  property p_lock_read;
    @(posedge ref_clk) disable iff (!resetn)
      req.rd && req.addr == wpd_pkg::CONTROL_ADDR |=> rdata[1:0] == {$past(s_q.lock), $past(s_q.permit)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("control read mismatch"); // RULE2

  property p_pin;
    @(posedge ref_clk) disable iff (!resetn)
      !s_q.permit |-> !watchdog_disable_req;
  endproperty
  a_pin: assert property (p_pin) else $error("pin acted without permit"); // RULE5

  property p_restart;
    @(posedge ref_clk) disable iff (!resetn)
      key_wr && !key_hit && req.wdata != wpd_pkg::KEY_BYTE_0 |=> s_q.seq == wpd_pkg::WPD_WAIT_B0;
  endproperty
  a_restart: assert property (p_restart) else $error("tracker not restarted"); // RULE8

  // any key byte short of the last one leaves the lock closed
  property p_key_relock;
    @(posedge ref_clk) disable iff (!resetn)
      key_wr && s_q.seq != wpd_pkg::WPD_WAIT_B2 |=> s_q.lock;
  endproperty
  a_key_relock: assert property (p_key_relock) else $error("key byte left lock open"); // RULE4

  // a complete key is refused while the watchdog config is locked
  property p_cfg_block;
    @(posedge ref_clk) disable iff (!resetn)
      key_wr && watchdog_config_lock |=> s_q.lock;
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("key opened lock under config lock"); // RULE3

  // lock is read-only: only key writes or config lock writes move it
  property p_lock_held;
    @(posedge ref_clk) disable iff (!resetn)
      !key_wr && !watchdog_config_lock_set |=> s_q.lock == $past(s_q.lock);
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("lock changed without cause"); // RULE1

  // both locks open let a write of one through
  property p_permit_set;
    @(posedge ref_clk) disable iff (!resetn)
      ctl_wr && req.wdata[wpd_pkg::PERMIT_BIT] && !s_q.lock && !watchdog_config_lock |=> s_q.permit;
  endproperty
  a_permit_set: assert property (p_permit_set) else $error("permit write of one lost"); // RULE6

  // clearing needs only the key lock open
  property p_permit_clear;
    @(posedge ref_clk) disable iff (!resetn)
      ctl_wr && !req.wdata[wpd_pkg::PERMIT_BIT] && !s_q.lock |=> !s_q.permit;
  endproperty
  a_permit_clear: assert property (p_permit_clear) else $error("permit write of zero lost"); // RULE6

  // without a control write the permit bit holds its value
  property p_permit_idle;
    @(posedge ref_clk) disable iff (!resetn)
      !ctl_wr |=> $stable(s_q.permit);
  endproperty
  a_permit_idle: assert property (p_permit_idle) else $error("permit moved without a write"); // RULE5

  // tracker sits in exactly one state, so a restart is never lost
  property p_seq_onehot;
    @(posedge ref_clk) disable iff (!resetn)
      $onehot(s_q.seq);
  endproperty
  a_seq_onehot: assert property (p_seq_onehot) else $error("tracker state not one-hot"); // RULE8

endmodule
`default_nettype wire

/* tb/wpd_host.sv */
// host model issuing byte register accesses
`timescale 1ns/100ps
`default_nettype none
module wpd_host (
  // clock
  input wire logic ref_clk,
  // register access
  output var wpd_pkg::wpd_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // one strobe, changed at falling edges; read data taken one cycle on
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    q = rdata;
    req <= '0;
    @(negedge ref_clk);
  endtask
  // key bytes back to back, nothing between them
  task automatic unlock();
    logic [7:0] k [3];
    k = '{wpd_pkg::KEY_BYTE_0, wpd_pkg::KEY_BYTE_1, wpd_pkg::KEY_BYTE_2};
    for (int i = 0; i < 3; i++) begin
      req <= '{wr: 1'b1, rd: 1'b0, addr: wpd_pkg::KEY_REGISTER_ADDR, wdata: k[i]};
      @(negedge ref_clk);
    end
    req <= '0;
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the pin disable lock block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: mismatch", $time); end end
module testbench;
  localparam logic [7:0] KA = wpd_pkg::KEY_REGISTER_ADDR;
  localparam logic [7:0] CA = wpd_pkg::CONTROL_ADDR;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_lock = 1'b0;
  logic cfg_set = 1'b0;
  logic pin = 1'b0;
  logic lock, permit, dis_req;
  logic [7:0] rdata, v, r, b;
  logic [1:0] st;
  logic [2:0] nxt;
  wpd_pkg::wpd_req_t req;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  wpd_host host (.ref_clk(ref_clk), .req(req), .rdata(rdata));
  wpd_lock dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata), .watchdog_config_lock(cfg_lock),
    .watchdog_config_lock_set(cfg_set), .watchdog_disable_pin(pin), .key_lock_status(lock),
    .pin_disable_permit(permit), .watchdog_disable_req(dis_req));
  // control byte expected with reserved bits kept zero
  function automatic logic [7:0] ctl(input logic l, input logic p);
    return {6'h00, l, p};
  endfunction
  // key byte wanted after cnt bytes of the sequence have matched
  function automatic logic [7:0] key_want(input logic [1:0] cnt);
    case (cnt)
      2'd0: return wpd_pkg::KEY_BYTE_0;
      2'd1: return wpd_pkg::KEY_BYTE_1;
      default: return wpd_pkg::KEY_BYTE_2;
    endcase
  endfunction
  // tracker model after one key write, config lock clear: {matched count, lock}
  function automatic logic [2:0] key_step(input logic [1:0] cnt, input logic [7:0] kb);
    if (kb == key_want(cnt))
      return (cnt == 2'd2) ? 3'b000 : {cnt + 2'd1, 1'b1};
    else if (kb == wpd_pkg::KEY_BYTE_0)
      return 3'b011;
    else
      return 3'b001;
  endfunction
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the some 180 cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hb9624962));
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    host.acc(1'b0, CA, 8'h00, r);
    `CHK(r, ctl(1'b1, 1'b0))
    host.acc(1'b1, CA, 8'h01, r);
    `CHK(permit, 1'b0)
    host.unlock();
    `CHK(lock, 1'b0)
    host.acc(1'b1, CA, 8'h01, r);
    host.acc(1'b0, CA, 8'h00, r);
    `CHK(r, ctl(1'b0, 1'b1))
    // pin only reaches the watchdog once permitted
    repeat (4) begin
      pin = 1'($urandom);
      #1;
      `CHK(dis_req, pin)
      @(negedge ref_clk);
    end
    v = 8'($urandom);
    host.acc(1'b1, KA, v, r);
    `CHK(lock, 1'b1)
    host.acc(1'b1, CA, 8'h00, r);
    `CHK(permit, 1'b1)
    host.acc(1'b0, KA, 8'h00, r);
    `CHK(r, 8'h00)
    host.acc(1'b0, 8'h36, 8'h00, r);
    `CHK(r, 8'h00)
    // broken sequence must not open the lock
    v = (v == 8'h1B) ? 8'h00 : v;
    host.acc(1'b1, KA, 8'h87, r);
    host.acc(1'b1, KA, 8'h65, r);
    host.acc(1'b1, KA, v, r);
    host.acc(1'b1, KA, 8'h1B, r);
    `CHK(lock, 1'b1)
    cfg_lock = 1'b1;
    host.unlock();
    `CHK(lock, 1'b1)
    cfg_lock = 1'b0;
    host.unlock();
    `CHK(lock, 1'b0)
    // open lock: permit may be cleared and set again
    host.acc(1'b1, CA, 8'h00, r);
    `CHK(permit, 1'b0)
    host.acc(1'b1, CA, 8'h01, r);
    `CHK(permit, 1'b1)
    cfg_set = 1'b1;
    @(negedge ref_clk);
    cfg_set = 1'b0;
    @(negedge ref_clk);
    `CHK(lock, 1'b1)
    // reset again in mid-run
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    `CHK({lock, permit}, 2'b10)
    // pin has no effect once reset has cleared the permit
    pin = 1'b1;
    #1;
    `CHK(dis_req, 1'b0)
    @(negedge ref_clk);
    // reserved bits store, permit frozen while locked
    v = 8'($urandom);
    host.acc(1'b1, CA, {v[7:2], 2'b01}, r);
    host.acc(1'b0, CA, 8'h00, r);
    `CHK(r, {v[7:2], 2'b10})
    // random key traffic against the tracker model, biased toward the wanted byte
    st = 2'd0;
    repeat (60) begin
      b = ($urandom % 2 == 0) ? key_want(st) : 8'($urandom);
      host.acc(1'b1, KA, b, r);
      nxt = key_step(st, b);
      st = nxt[2:1];
      `CHK(lock, nxt[0])
    end
    wrap_up();
  end
endmodule
`default_nettype wire
